/* logic/pci_change_unit.v */
// Pin change interrupt unit with APB register slave
`timescale 1ns/1ps
`default_nettype none
`include "pci_defines.vh"
module pci_change_unit #(
  parameter PW = 8
) (
  input wire mclk,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [PW-1:0] portAPins,
  input wire [PW-1:0] portBPins,
  input wire [PW-1:0] portCPins,
  input wire portEPin3,
  output reg changeIrq,
  output reg wakeReq,
  output reg eventIrq
);
  localparam NP = 4;
  reg [PW-1:0] rise_ff [0:NP-1];
  reg [PW-1:0] fall_ff [0:NP-1];
  reg masterEn_ff;
  reg unitOff_ff;
  reg [1:0] evStat_ff;
  reg [1:0] evMask_ff;
  reg [31:0] nxt_prdata;
  reg nxt_slverr;
  wire [PW-1:0] pinsIn [0:NP-1];
  wire [PW-1:0] riseSeen [0:NP-1];
  wire [PW-1:0] fallSeen [0:NP-1];
  wire [PW-1:0] flags [0:NP-1];
  wire [PW-1:0] newEv [0:NP-1];
  wire [PW-1:0] portMask [0:NP-1];
  wire [NP-1:0] flagWr;
  wire [NP-1:0] anyNew;
  wire [NP-1:0] anyFlag;
  wire [`PCI_ADDR_W-1:0] addr;
  wire acc;
  wire wrAcc;
  wire rdAcc;
  wire wrOk;
  wire rdOk;
  wire summary;
  wire [1:0] evSet;
  integer i;
  integer j;

  // Port E has only pin 3 covered
  assign pinsIn[0] = portAPins;
  assign pinsIn[1] = portBPins;
  assign pinsIn[2] = portCPins;
  assign pinsIn[3] = {{(PW-1){1'b0}}, portEPin3} << `PCI_E_PIN;
  assign portMask[0] = {PW{1'b1}};
  assign portMask[1] = {PW{1'b1}};
  assign portMask[2] = {PW{1'b1}};
  assign portMask[3] = {{(PW-1){1'b0}}, 1'b1} << `PCI_E_PIN;

  assign addr = paddr[`PCI_ADDR_W-1:0];
  assign acc = psel & penable & pready;
  assign wrAcc = acc & pwrite;
  assign rdAcc = acc & ~pwrite;
  // Refused accesses must not touch any register, flags included
  assign wrOk = wrAcc & ~pslverr;
  assign rdOk = rdAcc & ~pslverr;

  function [`PCI_ADDR_W-1:0] portOff;
    input integer port;
    input [1:0] kind;
    integer off;
    begin
      off = port * 32'h0000_000C + kind * 32'h0000_0004;
      portOff = off[`PCI_ADDR_W-1:0];
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < NP; g = g + 1)
    begin : gPort
      pci_pin_sync #(.W(PW)) uSync (
        .mclk(mclk),
        .reset_n(reset_n),
        .pinIn(pinsIn[g]),
        .riseSeen(riseSeen[g]),
        .fallSeen(fallSeen[g])
      );
      assign flagWr[g] = wrOk & (addr == portOff(g, 2'd2));
      pci_edge_flags #(.W(PW)) uFlags (
        .mclk(mclk),
        .reset_n(reset_n),
        .unitOff(unitOff_ff),
        .riseSeen(riseSeen[g]),
        .fallSeen(fallSeen[g]),
        .riseEn(rise_ff[g] & portMask[g]),
        .fallEn(fall_ff[g] & portMask[g]),
        .flagWr(flagWr[g]),
        .flagWrData(pwdata[PW-1:0] & portMask[g]),
        .flags(flags[g]),
        .newEvents(newEv[g])
      );
      assign anyNew[g] = |newEv[g];
      assign anyFlag[g] = |flags[g];
    end
  endgenerate

  assign summary = |anyFlag;
  // Event 0: new change seen, event 1: new change seen while the master enable is set
  assign evSet = {masterEn_ff & (|anyNew), |anyNew};

  always @*
  begin
    nxt_prdata = 32'h0000_0000;
    nxt_slverr = 1'b0;
    for (i = 0; i < NP; i = i + 1)
    begin
      if (addr == portOff(i, 2'd0))
        nxt_prdata[PW-1:0] = rise_ff[i];
      if (addr == portOff(i, 2'd1))
        nxt_prdata[PW-1:0] = fall_ff[i];
      if (addr == portOff(i, 2'd2))
        nxt_prdata[PW-1:0] = flags[i];
    end
    case (addr)
      `PCI_OFF_RISE_A, `PCI_OFF_FALL_A, `PCI_OFF_FLAG_A,
      `PCI_OFF_RISE_B, `PCI_OFF_FALL_B, `PCI_OFF_FLAG_B,
      `PCI_OFF_RISE_C, `PCI_OFF_FALL_C, `PCI_OFF_FLAG_C,
      `PCI_OFF_RISE_E, `PCI_OFF_FALL_E, `PCI_OFF_FLAG_E:
        nxt_slverr = 1'b0;
      `PCI_OFF_IRQ_EN:
        nxt_prdata[`PCI_BIT_MASTER_EN] = masterEn_ff;
      `PCI_OFF_IRQ_REQ:
        nxt_prdata[`PCI_BIT_SUMMARY] = summary;
      `PCI_OFF_DISABLE:
        nxt_prdata[`PCI_BIT_DISABLE] = unitOff_ff;
      `PCI_OFF_EV_STAT:
        nxt_prdata[1:0] = evStat_ff;
      `PCI_OFF_EV_MASK:
        nxt_prdata[1:0] = evMask_ff;
      default:
        nxt_slverr = 1'b1;
    endcase
    if (paddr[31:`PCI_ADDR_W] != {(32-`PCI_ADDR_W){1'b0}} ||
        paddr[1:0] != 2'b00)
      nxt_slverr = 1'b1;
  end

  // One wait state: setup, wait, then ready
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & nxt_slverr;
      prdata <= (psel & penable & ~pready & ~pwrite & ~nxt_slverr) ?
        nxt_prdata : 32'h0000_0000;
    end
  end

  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rise_ff[0] <= `PCI_RST_BYTE;
      rise_ff[1] <= `PCI_RST_BYTE;
      rise_ff[2] <= `PCI_RST_BYTE;
      rise_ff[3] <= `PCI_RST_BYTE;
      fall_ff[0] <= `PCI_RST_BYTE;
      fall_ff[1] <= `PCI_RST_BYTE;
      fall_ff[2] <= `PCI_RST_BYTE;
      fall_ff[3] <= `PCI_RST_BYTE;
      masterEn_ff <= 1'b0;
      unitOff_ff <= 1'b0;
      evMask_ff <= 2'b00;
    end
    else if (wrOk)
    begin
      for (j = 0; j < NP; j = j + 1)
      begin
        if (addr == portOff(j, 2'd0))
          rise_ff[j] <= pwdata[PW-1:0] & portMask[j];
        if (addr == portOff(j, 2'd1))
          fall_ff[j] <= pwdata[PW-1:0] & portMask[j];
      end
      if (addr == `PCI_OFF_IRQ_EN)
        masterEn_ff <= pwdata[`PCI_BIT_MASTER_EN];
      if (addr == `PCI_OFF_DISABLE)
        unitOff_ff <= pwdata[`PCI_BIT_DISABLE];
      if (addr == `PCI_OFF_EV_MASK)
        evMask_ff <= pwdata[1:0];
    end
  end

  // Read clears only the bits it returned: an event caught after the
  // data was captured stays pending; a new event in the same cycle wins
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      evStat_ff <= 2'b00;
    else if (rdOk & (addr == `PCI_OFF_EV_STAT))
      evStat_ff <= (evStat_ff & ~prdata[1:0]) | evSet;
    else
      evStat_ff <= evStat_ff | evSet;
  end

  // Flags are set on the edge itself, so they are already valid when
  // the core sees the wake request one cycle later
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      changeIrq <= 1'b0;
      wakeReq <= 1'b0;
      eventIrq <= 1'b0;
    end
    else
    begin
      changeIrq <= masterEn_ff & summary;
      wakeReq <= masterEn_ff & summary;
      eventIrq <= |(evStat_ff & evMask_ff);
    end
  end
endmodule // pci_change_unit
`default_nettype wire

/* logic/pci_defines.vh */
// Register offsets, field positions and reset values of the pin change unit
`ifndef PCI_DEFINES_VH
`define PCI_DEFINES_VH
`define PCI_ADDR_W 8
`define PCI_OFF_RISE_A 8'h00
`define PCI_OFF_FALL_A 8'h04
`define PCI_OFF_FLAG_A 8'h08
`define PCI_OFF_RISE_B 8'h0C
`define PCI_OFF_FALL_B 8'h10
`define PCI_OFF_FLAG_B 8'h14
`define PCI_OFF_RISE_C 8'h18
`define PCI_OFF_FALL_C 8'h1C
`define PCI_OFF_FLAG_C 8'h20
`define PCI_OFF_RISE_E 8'h24
`define PCI_OFF_FALL_E 8'h28
`define PCI_OFF_FLAG_E 8'h2C
`define PCI_OFF_IRQ_EN 8'h30
`define PCI_OFF_IRQ_REQ 8'h34
`define PCI_OFF_DISABLE 8'h38
`define PCI_OFF_EV_STAT 8'h3C
`define PCI_OFF_EV_MASK 8'h40
`define PCI_BIT_MASTER_EN 0
`define PCI_BIT_SUMMARY 0
`define PCI_BIT_DISABLE 0
`define PCI_BIT_WAKE 1
`define PCI_E_PIN 3
`define PCI_RST_BYTE 8'h00
`define PCI_SYNC_STAGES 2
`endif

/* logic/pci_pin_sync.v */
// Two-stage synchroniser and edge detector for one port of pins
`timescale 1ns/1ps
`default_nettype none
module pci_pin_sync #(
  parameter W = 8
) (
  input wire mclk,
  input wire reset_n,
  input wire [W-1:0] pinIn,
  output wire [W-1:0] riseSeen,
  output wire [W-1:0] fallSeen
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;
  reg [W-1:0] prev_ff;

  // First stage feeds only the second stage
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
      prev_ff <= {W{1'b0}};
    end
    else
    begin
      meta_ff <= pinIn;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign riseSeen = sync_ff & ~prev_ff;
  assign fallSeen = ~sync_ff & prev_ff;
endmodule // pci_pin_sync
`default_nettype wire

/* logic/pci_edge_flags.v */
// Edge enable and sticky change flag bits for one port
`timescale 1ns/1ps
`default_nettype none
module pci_edge_flags #(
  parameter W = 8
) (
  input wire mclk,
  input wire reset_n,
  input wire unitOff,
  input wire [W-1:0] riseSeen,
  input wire [W-1:0] fallSeen,
  input wire [W-1:0] riseEn,
  input wire [W-1:0] fallEn,
  input wire flagWr,
  input wire [W-1:0] flagWrData,
  output wire [W-1:0] flags,
  output wire [W-1:0] newEvents
);
  reg [W-1:0] flag_ff;
  wire [W-1:0] hit;
  wire [W-1:0] nxt_flag;

  // Either polarity may be armed on the same pin
  assign hit = unitOff ? {W{1'b0}} :
    ((riseSeen & riseEn) | (fallSeen & fallEn));
  // Set beats a clearing write in the same cycle
  assign nxt_flag = (flagWr ? flagWrData : flag_ff) | hit;

  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      flag_ff <= {W{1'b0}};
    else
      flag_ff <= nxt_flag;
  end

  assign flags = flag_ff;
  assign newEvents = hit;
endmodule // pci_edge_flags
`default_nettype wire

/* bench/pci_change_unit_assertions.sv */
// Port assertions for the pin change unit
`timescale 1ns/1ps
`default_nettype none
`include "pci_defines.vh"
module pci_change_unit_assertions (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic changeIrq,
  input wire logic wakeReq,
  input wire logic eventIrq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence s_wait; psel && penable && !pready; endsequence
  sequence s_done; pready ##1 !pready; endsequence
  property p_oneWait; s_wait |=> s_done; endproperty
  property p_errRdy; pslverr |-> pready; endproperty
  property p_rdIdle; !pready |-> prdata == 32'h0; endproperty
  property p_badAddr; s_wait and paddr[1:0] != 2'h0 |=> pslverr; endproperty
  property p_rstQuiet; $rose(reset_n) |-> !changeIrq && !eventIrq; endproperty
  property p_wake; wakeReq == changeIrq; endproperty
  property p_master;
    pready && !pwrite && paddr == {24'h0, `PCI_OFF_IRQ_EN} && !prdata[0]
      |-> !changeIrq;
  endproperty
  // Only a register write may take a raised interrupt down
  property p_sticky;
    changeIrq && !($past(pready) && $past(pwrite)) |=> changeIrq;
  endproperty
  a_oneWait: assert property (p_oneWait) else $error("one wait");
  a_errRdy: assert property (p_errRdy) else $error("err w/o ready");
  a_rdIdle: assert property (p_rdIdle) else $error("idle rdata");
  a_badAddr: assert property (p_badAddr) else $error("misaligned");
  a_rstQuiet: assert property (p_rstQuiet) else $error("reset out");
  a_wake: assert property (p_wake) else $error("wake");
  a_master: assert property (p_master) else $error("master");
  a_sticky: assert property (p_sticky) else $error("sticky");
endmodule // pci_change_unit_assertions
bind pci_change_unit pci_change_unit_assertions u_chk (.mclk(mclk),
  .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .changeIrq(changeIrq), .wakeReq(wakeReq), .eventIrq(eventIrq));
`default_nettype wire

/* bench/pci_pin_driver.sv */
// External pin driver model
`timescale 1ns/1ps
`default_nettype none
module pci_pin_driver (
  input wire logic mclk,
  input wire logic [24:0] want,
  output logic [7:0] pinA,
  output logic [7:0] pinB,
  output logic [7:0] pinC,
  output logic pinE
);
  logic [24:0] held_ff = 25'h0;
  // Levels move on the rising edge of mclk, one cycle after want changes
  always @(posedge mclk)
  begin
    held_ff <= want;
  end
  assign {pinE, pinC, pinB, pinA} = held_ff;
endmodule // pci_pin_driver
`default_nettype wire

/* bench/pci_change_unit_tb_top.sv */
// Self-checking bench for the pin change unit
`timescale 1ns/1ps
`default_nettype none
`include "pci_defines.vh"
`define CHK(n, x, g) begin comparisons++; if ((g) !== (x)) begin \
  bad_count++; $display("Error %s exp %h got %h", n, x, g); end end
module pci_change_unit_tb_top;
  logic mclk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, v, m;
  logic pready, pslverr, changeIrq, wakeReq, eventIrq, e, pinE;
  logic [7:0] pinA, pinB, pinC;
  logic [24:0] want = 0;
  int bad_count = 0, comparisons = 0;
  task finish_test;
    $display("compared %0d mismatched %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic io(input logic w, input logic [31:0] a, d);
    int n = 0;
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1 && ++n < 20);
    v = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 20)
    begin
      bad_count++;
      finish_test();
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Flag offsets of ports A, B, C, E sit twelve bytes apart
  task automatic flags(input logic [31:0] x);
    for (int i = 0; i < 4; i++)
    begin
      io(0, `PCI_OFF_FLAG_A + 8'h0C * i, 0);
      `CHK("flag", x[8*i+:8], v[7:0])
      m = v ^ 32'hFF;
      io(0, `PCI_OFF_FLAG_A + 8'h0C * i, 0);
      io(1, `PCI_OFF_FLAG_A + 8'h0C * i, v & m);
    end
  endtask
  initial
  begin
    forever #2.5 mclk = ~mclk;
  end
  initial
  begin
    repeat (4) @(posedge mclk);
    reset_n <= 1;
    io(0, `PCI_OFF_IRQ_EN, 0);
    `CHK("irqEn", 1'b0, v[0])
    io(1, `PCI_OFF_RISE_A, 32'h01);
    io(1, `PCI_OFF_FALL_B, 32'h02);
    io(1, `PCI_OFF_RISE_C, 32'h80);
    io(1, `PCI_OFF_FALL_C, 32'h80);
    io(1, `PCI_OFF_RISE_E, 32'hFF);
    io(0, `PCI_OFF_RISE_E, 0);
    `CHK("riseE", 8'h08, v[7:0])
    want <= 25'h1FFFFFF;
    tick(6);
    `CHK("noIrq", 1'b0, changeIrq)
    io(0, `PCI_OFF_IRQ_REQ, 0);
    `CHK("sum", 1'b1, v[0])
    io(1, `PCI_OFF_IRQ_EN, 32'h1);
    tick(3);
    `CHK("irq", 1'b1, changeIrq)
    `CHK("wake", 1'b1, wakeReq)
    flags(32'h08800001);
    tick(3);
    `CHK("irqClr", 1'b0, changeIrq)
    io(0, `PCI_OFF_IRQ_REQ, 0);
    `CHK("sumClr", 1'b0, v[0])
    want <= 0;
    tick(6);
    flags(32'h00800200);
    want <= 25'h1FFFFFF;
    io(1, `PCI_OFF_FLAG_A, 0);
    tick(6);
    flags(32'h08800001);
    `CHK("evMasked", 1'b0, eventIrq)
    io(1, `PCI_OFF_EV_MASK, 32'h3);
    tick(2);
    `CHK("evIrq", 1'b1, eventIrq)
    io(0, `PCI_OFF_EV_STAT, 0);
    `CHK("evStat", 2'h3, v[1:0])
    tick(2);
    `CHK("evClr", 1'b0, eventIrq)
    io(1, `PCI_OFF_DISABLE, 32'h1);
    want <= 0;
    tick(6);
    flags(0);
    io(0, 32'h44, 0);
    `CHK("unmapped", 1'b1, e)
    io(0, 32'h31, 0);
    `CHK("misaligned", 1'b1, e)
    io(1, 32'h108, 32'hFF);
    `CHK("range", 1'b1, e)
    io(0, `PCI_OFF_FLAG_A, 0);
    `CHK("rangeWr", 8'h00, v[7:0])
    reset_n <= 0;
    repeat (2) @(posedge mclk);
    reset_n <= 1;
    io(0, `PCI_OFF_RISE_A, 0);
    `CHK("riseRst", 8'h00, v[7:0])
    finish_test();
  end
  pci_pin_driver i_pci_pin_driver (.mclk(mclk), .want(want), .pinA(pinA),
    .pinB(pinB), .pinC(pinC), .pinE(pinE));
  pci_change_unit #(.PW(8)) i_pci_change_unit (.mclk(mclk),
    .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .portAPins(pinA), .portBPins(pinB),
    .portCPins(pinC), .portEPin3(pinE), .changeIrq(changeIrq),
    .wakeReq(wakeReq), .eventIrq(eventIrq));
endmodule // pci_change_unit_tb_top
`default_nettype wire
